// file: hw/dps_dancer_trim.sv
// Dancer roller LOOP_ACTIVE_FLAG speed trim with APB register access
//
// How it works
// [R1] Dancer control only for action codes 40..43
// [R2] LOOP_ACTIVE_FLAG correction added to main speed command
// [R3] Ratio mode scales correction by main speed
// [R4] Feedback scaled per range to 0..100%
// [R5] Assigned select input gates dancer control
// [R6] Code 0 or input off: plain drive
// [R7] Select on while running captures output frequency
// [R8] Select off: run at valid set frequency
// [R9] Upper flag: feedback above set limit
// [R10] Lower flag: feedback below set limit
// [R11] Direction output on only for forward rotation
// [R12] Loop-active output via codes 47 or 147
// [R13] Codes 100 and up invert terminal polarity
// [R14] Set point 9999 means 50 percent
// [R15] 0..100% maps bias to gain frequency
// [R16] Ratio uses main speed clamped between bias and gain frequencies
// [R17] Feedback terminal refused as main speed in dancer modes (action codes 40..43)
// [R18] Thermistor use excludes second analog input
// [R19] Configurer disables output suspension function
// [R20] Main speed ramps with second accel/decel
// [R21] Loop-active held while loop runs stopped
// [R22] LOOP_ACTIVE_FLAG and flags update once per sample
`timescale 1ns/1ps
`default_nettype none
module dps_dancer_trim
   import dps_pkg::*;
#(
   parameter int SampleCyc = SAMPLE_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive side
   input wire dps_drive_t drive,
   input wire logic loopSelectInput,
   input wire logic [11:0] feedbackRaw,
   output logic [15:0] speedCmd,
   // Status terminals, active level set by function code
   output logic outTermA,
   output logic outTermB
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      dps_cfg_t cfg;
      dps_mode_t mode;
      logic [23:0] sampCnt;
      logic [15:0] fbPct;
      logic signed [12:0] errPrev;
      logic signed [23:0] integ;
      logic signed [11:0] corr;
      logic [15:0] base;
      logic upF;
      logic loF;
      logic rejF;
      logic [15:0] speed;
      logic termA;
      logic termB;
      logic rdy;
      logic err;
      logic [31:0] rdat;
   } dps_state_t;

   dps_state_t s_q;
   dps_state_t s_d;

   logic tick;
   logic dancerMode;
   logic enable;
   logic ratioMode;
   logic [15:0] mainSel;
   logic [29:0] fbProd;
   logic signed [13:0] fbOff;
   logic [15:0] fbNew;
   logic [15:0] spEff;
   logic signed [12:0] errNow;
   logic signed [23:0] integNew;
   logic signed [25:0] pidSum;
   logic signed [17:0] span;
   logic signed [17:0] mOff;
   logic signed [17:0] mult;
   logic signed [29:0] prod;
   logic signed [42:0] scaled;
   logic signed [18:0] sum;
   logic [31:0] rdMux;
   logic hit;

   function automatic logic termFn(input logic [7:0] code, input logic up,
                                    input logic lo, input logic dir, input logic act);
      logic [7:0] base;
      logic v;
      base = (code >= FN_INVERT) ? code - FN_INVERT : code;
      unique case (base)
         FN_UPPER: v = up;
         FN_LOWER: v = lo;
         FN_DIR: v = dir;
         FN_LOOP: v = act;
         default: v = 1'b0;
      endcase
      termFn = (code >= FN_INVERT) ? ~v : v; // see [R13]
   endfunction

   // ----------------------------------------
   // Mode decode and sources
   // ----------------------------------------
   // One shared sample tick keeps LOOP_ACTIVE_FLAG, ramp and flags in step with each other
   assign tick = (s_q.sampCnt == 24'(SampleCyc - 1)); // see [R22]
   assign dancerMode = (s_q.cfg.action >= ACT_REV_FIX)
                       && (s_q.cfg.action <= ACT_FWD_RAT); // see [R1]
   assign enable = dancerMode && ((s_q.cfg.inSel != IN_LOOP_SEL)
                   || loopSelectInput); // see [R5] [R6]
   assign ratioMode = (s_q.cfg.action == ACT_REV_RAT)
                      || (s_q.cfg.action == ACT_FWD_RAT); // see [R3]

   always_comb begin
      mainSel = drive.digitalFreq;
      unique case (s_q.cfg.mainSrc)
         SRC_TERM2: mainSel = (s_q.cfg.therm != NO_FUNC) ? 16'h0000
                              : drive.term2Freq; // see [R18]
         SRC_TERM4: mainSel = dancerMode ? 16'h0000 : drive.term4Freq; // see [R17]
         default: mainSel = drive.digitalFreq;
      endcase
   end

   // ----------------------------------------
   // Feedback scaling and LOOP_ACTIVE_FLAG
   // ----------------------------------------
   always_comb begin
      fbOff = 14'(signed'({2'b00, feedbackRaw}));
      fbProd = 30'({13'h0000, feedbackRaw} * K_0_10V);
      unique case (s_q.cfg.fbRange)
         RNG_4_20MA: begin
            fbOff = 14'(signed'({2'b00, feedbackRaw}) - signed'({2'b00, ADC_4MA}));
            fbProd = (fbOff < 0) ? 30'h0
                     : 30'($unsigned(fbOff) * K_4_20MA); // see [R4]
         end
         RNG_0_5V: fbProd = 30'({13'h0000, feedbackRaw} * K_0_5V);
         default: fbProd = 30'({13'h0000, feedbackRaw} * K_0_10V);
      endcase
      fbNew = (fbProd[29:16] > PCT_FULL[13:0]) ? PCT_FULL : {2'b00, fbProd[29:16]};
   end

   assign spEff = (s_q.cfg.setPt == NO_FUNC) ? SP_DEFAULT
                  : ((s_q.cfg.setPt > PCT_FULL) ? PCT_FULL : s_q.cfg.setPt); // see [R14]

   always_comb begin
      // Reverse action drives output up when feedback is below set point
      if (s_q.cfg.action[0]) begin
         errNow = 13'(signed'({1'b0, s_q.fbPct[11:0]}) - signed'({1'b0, spEff[11:0]}));
      end else begin
         errNow = 13'(signed'({1'b0, spEff[11:0]}) - signed'({1'b0, s_q.fbPct[11:0]}));
      end
      integNew = s_q.integ + 24'(errNow * signed'({1'b0, s_q.cfg.ki}));
      // Anti-windup: integrator clamped to the full output range
      if (integNew > 24'sd16000) begin
         integNew = 24'sd16000;
      end else if (integNew < -24'sd16000) begin
         integNew = -24'sd16000;
      end
      pidSum = (26'(errNow * signed'({1'b0, s_q.cfg.kp})) + 26'(integNew)
               + 26'((errNow - s_q.errPrev) * signed'({1'b0, s_q.cfg.kd}))) >>> 4;
   end

   // ----------------------------------------
   // Correction to frequency
   // ----------------------------------------
   always_comb begin
      span = 18'(signed'({2'b00, s_q.cfg.gainF}) - signed'({2'b00, s_q.cfg.biasF}));
      mOff = 18'(signed'({2'b00, mainSel}) - signed'({2'b00, s_q.cfg.biasF}));
      if (mOff < 0) begin
         mOff = 18'sd0;
      end else if (mOff > span) begin
         mOff = span;
      end
      mult = ratioMode ? mOff : span; // see [R3] [R16]
      prod = 30'(s_q.corr * mult); // see [R15]
      scaled = (43'(prod) * signed'({1'b0, INV_1000})) >>> 20;
      sum = 19'(signed'({3'b000, s_q.base}) + scaled[18:0]); // see [R2]
   end

   // ----------------------------------------
   // Register read mux
   // ----------------------------------------
   always_comb begin
      hit = 1'b1;
      rdMux = 32'h0;
      unique case (paddr)
         OFS_ACTION: rdMux = {24'h0, s_q.cfg.action};
         OFS_SETPT: rdMux = {16'h0, s_q.cfg.setPt};
         OFS_UPLIM: rdMux = {16'h0, s_q.cfg.upLim};
         OFS_LOLIM: rdMux = {16'h0, s_q.cfg.loLim};
         OFS_FBRANGE: rdMux = {30'h0, s_q.cfg.fbRange};
         OFS_OUTSEL: rdMux = {16'h0, s_q.cfg.outSelB, s_q.cfg.outSelA};
         OFS_INSEL: rdMux = {24'h0, s_q.cfg.inSel};
         OFS_GAINS: rdMux = {8'h0, s_q.cfg.kd, s_q.cfg.ki, s_q.cfg.kp};
         OFS_BIASF: rdMux = {16'h0, s_q.cfg.biasF};
         OFS_GAINF: rdMux = {16'h0, s_q.cfg.gainF};
         OFS_THERM: rdMux = {16'h0, s_q.cfg.therm};
         OFS_MAINSRC: rdMux = {30'h0, s_q.cfg.mainSrc};
         OFS_ACC2: rdMux = {16'h0, s_q.cfg.acc2};
         OFS_DEC2: rdMux = {16'h0, s_q.cfg.dec2};
         OFS_STATUS: rdMux = {s_q.fbPct, 12'h0, s_q.rejF, s_q.loF, s_q.upF,
                              s_q.mode == MODE_DANCER};
         OFS_SPEED: rdMux = {16'h0, s_q.speed};
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      // One wait state: ready rises in the second access cycle
      s_d.rdy = psel && penable && !s_q.rdy;
      s_d.err = psel && penable && !s_q.rdy && !hit;
      s_d.rdat = (psel && penable && !s_q.rdy) ? rdMux : 32'h0;
      if (psel && penable && s_q.rdy && pwrite) begin
         unique case (paddr)
            OFS_ACTION: s_d.cfg.action = pwdata[7:0];
            OFS_SETPT: s_d.cfg.setPt = pwdata[15:0];
            OFS_UPLIM: s_d.cfg.upLim = pwdata[15:0];
            OFS_LOLIM: s_d.cfg.loLim = pwdata[15:0];
            OFS_FBRANGE: s_d.cfg.fbRange = pwdata[1:0];
            OFS_OUTSEL: {s_d.cfg.outSelB, s_d.cfg.outSelA} = pwdata[15:0];
            OFS_INSEL: s_d.cfg.inSel = pwdata[7:0];
            OFS_GAINS: {s_d.cfg.kd, s_d.cfg.ki, s_d.cfg.kp} = pwdata[23:0];
            OFS_BIASF: s_d.cfg.biasF = pwdata[15:0];
            OFS_GAINF: s_d.cfg.gainF = pwdata[15:0];
            OFS_THERM: s_d.cfg.therm = pwdata[15:0];
            OFS_MAINSRC: s_d.cfg.mainSrc = pwdata[1:0];
            OFS_ACC2: s_d.cfg.acc2 = pwdata[15:0];
            OFS_DEC2: s_d.cfg.dec2 = pwdata[15:0];
            default: s_d.rdat = 32'h0;
         endcase
      end
      s_d.sampCnt = tick ? 24'h0 : s_q.sampCnt + 24'h1;
      s_d.rejF = ((s_q.cfg.mainSrc == SRC_TERM4) && dancerMode)
                 || ((s_q.cfg.mainSrc == SRC_TERM2) && (s_q.cfg.therm != NO_FUNC));
      s_d.mode = enable ? MODE_DANCER : MODE_NORMAL;
      if (enable && s_q.mode == MODE_NORMAL) begin
         // Bumpless entry: loop starts from the output frequency if the motor is running, else from the main speed
         s_d.base = drive.running ? drive.outFreq : mainSel; // see [R7]
         s_d.integ = 24'sd0;
         s_d.errPrev = 13'sd0;
         s_d.corr = 12'sd0;
      end else if (enable && tick) begin
         if (s_q.base < mainSel) begin
            s_d.base = (mainSel - s_q.base > s_q.cfg.acc2) ? s_q.base + s_q.cfg.acc2
                       : mainSel; // see [R20]
         end else begin
            s_d.base = (s_q.base - mainSel > s_q.cfg.dec2) ? s_q.base - s_q.cfg.dec2
                       : mainSel; // see [R20]
         end
         s_d.integ = integNew; // see [R22]
         s_d.errPrev = errNow;
         s_d.corr = (pidSum > 26'sd1000) ? 12'sd1000
                    : (pidSum < -26'sd1000) ? -12'sd1000 : 12'(pidSum);
      end else if (!enable) begin
         s_d.base = mainSel; // see [R8]
         s_d.corr = 12'sd0; // see [R6]
         s_d.integ = 24'sd0;
      end
      // Flags compare the previous sample, so they lag by one sample period
      if (tick) begin
         s_d.fbPct = fbNew; // see [R4] [R22]
         s_d.upF = dancerMode && (s_q.cfg.upLim != NO_FUNC)
                   && (s_q.fbPct > s_q.cfg.upLim); // see [R9]
         s_d.loF = dancerMode && (s_q.cfg.loLim != NO_FUNC)
                   && (s_q.fbPct < s_q.cfg.loLim); // see [R10]
      end
      if (!enable) begin
         s_d.speed = mainSel; // see [R6] [R8]
      end else if (sum < 0) begin
         s_d.speed = 16'h0000;
      end else if (sum > 19'sd65535) begin
         s_d.speed = 16'hffff;
      end else begin
         s_d.speed = sum[15:0]; // see [R2]
      end
      s_d.termA = termFn(s_q.cfg.outSelA, s_q.upF, s_q.loF,
                         drive.running && drive.fwdShown,
                         s_q.mode == MODE_DANCER); // see [R11] [R12] [R21]
      s_d.termB = termFn(s_q.cfg.outSelB, s_q.upF, s_q.loF,
                         drive.running && drive.fwdShown,
                         s_q.mode == MODE_DANCER); // see [R11] [R12] [R21]
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.mode <= MODE_NORMAL;
         s_q.cfg.setPt <= NO_FUNC;
         s_q.cfg.upLim <= NO_FUNC;
         s_q.cfg.loLim <= NO_FUNC;
         s_q.cfg.gainF <= GAINF_RST;
         s_q.cfg.therm <= NO_FUNC;
         s_q.cfg.mainSrc <= SRC_DIGITAL;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdat;
   assign pready = s_q.rdy;
   assign pslverr = s_q.err;
   assign speedCmd = s_q.speed;
   assign outTermA = s_q.termA;
   assign outTermB = s_q.termB;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_mode_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R1]
      (s_q.mode == MODE_DANCER) |-> $past(dancerMode))
      else $error("dancer mode outside action codes");
   chk_sel_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R5]
      (dancerMode && s_q.cfg.inSel == IN_LOOP_SEL && !loopSelectInput)
      |=> s_q.mode == MODE_NORMAL)
      else $error("loop ran with select input off");
   chk_normal_speed: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R6]
      !enable |=> speedCmd == $past(mainSel))
      else $error("correction applied in normal drive");
   chk_capture: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R7]
      (enable && s_q.mode == MODE_NORMAL && drive.running)
      |=> s_q.base == $past(drive.outFreq))
      else $error("output frequency not captured");
   chk_entry_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R7]
      (enable && s_q.mode == MODE_NORMAL)
      |=> s_q.corr == 12'sd0)
      else $error("correction not cleared on loop entry");
   chk_upper_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R9]
      (tick && !dancerMode) |=> !s_q.upF)
      else $error("upper flag outside dancer modes");
   chk_upper_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R9]
      (tick && dancerMode && s_q.cfg.upLim != NO_FUNC && s_q.fbPct > s_q.cfg.upLim)
      |=> s_q.upF)
      else $error("upper flag missed");
   chk_lower_flag: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R10]
      (tick && dancerMode && s_q.cfg.loLim != NO_FUNC && s_q.fbPct < s_q.cfg.loLim)
      |=> s_q.loF)
      else $error("lower flag missed");
   chk_dir_term: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R11]
      (s_q.cfg.outSelA == FN_DIR)
      |=> outTermA == $past(drive.running && drive.fwdShown))
      else $error("direction terminal wrong");
   chk_loop_term: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R12] [R13]
      (s_q.cfg.outSelB == FN_LOOP + FN_INVERT && s_q.mode == MODE_DANCER)
      |=> !outTermB)
      else $error("inverted loop-active terminal wrong");
   chk_term4_refused: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R17]
      (dancerMode && s_q.cfg.mainSrc == SRC_TERM4) |=> s_q.rejF)
      else $error("feedback terminal accepted as main speed");
   chk_sample_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // see [R22]
      (!tick && enable && s_q.mode == MODE_DANCER) |=> $stable(s_q.corr))
      else $error("correction changed between samples");
endmodule // dps_dancer_trim
`default_nettype wire

// file: hw/dps_pkg.sv
// Package: register map, codes and constants of the dancer speed trim block
package dps_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_ACTION = 8'h00;
   localparam logic [7:0] OFS_SETPT = 8'h04;
   localparam logic [7:0] OFS_UPLIM = 8'h08;
   localparam logic [7:0] OFS_LOLIM = 8'h0c;
   localparam logic [7:0] OFS_FBRANGE = 8'h10;
   localparam logic [7:0] OFS_OUTSEL = 8'h14;
   localparam logic [7:0] OFS_INSEL = 8'h18;
   localparam logic [7:0] OFS_GAINS = 8'h1c;
   localparam logic [7:0] OFS_BIASF = 8'h20;
   localparam logic [7:0] OFS_GAINF = 8'h24;
   localparam logic [7:0] OFS_THERM = 8'h28;
   localparam logic [7:0] OFS_MAINSRC = 8'h2c;
   localparam logic [7:0] OFS_ACC2 = 8'h30;
   localparam logic [7:0] OFS_DEC2 = 8'h34;
   localparam logic [7:0] OFS_STATUS = 8'h38;
   localparam logic [7:0] OFS_SPEED = 8'h3c;
   // ----------------------------------------
   // Codes and reset values
   // ----------------------------------------
   localparam logic [7:0] ACT_REV_FIX = 8'h28;
   localparam logic [7:0] ACT_FWD_FIX = 8'h29;
   localparam logic [7:0] ACT_REV_RAT = 8'h2a;
   localparam logic [7:0] ACT_FWD_RAT = 8'h2b;
   localparam logic [7:0] IN_LOOP_SEL = 8'h0e;
   localparam logic [7:0] FN_LOWER = 8'h0e;
   localparam logic [7:0] FN_UPPER = 8'h0f;
   localparam logic [7:0] FN_DIR = 8'h10;
   localparam logic [7:0] FN_LOOP = 8'h2f;
   localparam logic [7:0] FN_INVERT = 8'h64;
   localparam logic [15:0] NO_FUNC = 16'h270f;
   localparam logic [15:0] SP_DEFAULT = 16'h01f4;
   localparam logic [15:0] PCT_FULL = 16'h03e8;
   localparam logic [15:0] GAINF_RST = 16'h1770;
   localparam logic [1:0] RNG_4_20MA = 2'h0;
   localparam logic [1:0] RNG_0_5V = 2'h1;
   localparam logic [1:0] RNG_0_10V = 2'h2;
   localparam logic [1:0] SRC_TERM2 = 2'h0;
   localparam logic [1:0] SRC_TERM4 = 2'h1;
   localparam logic [1:0] SRC_DIGITAL = 2'h2;
   // Feedback scale factors, per-mille = (raw - offset) * k >> 16
   localparam logic [11:0] ADC_4MA = 12'h333;
   localparam logic [16:0] K_4_20MA = 17'h04e25;
   localparam logic [16:0] K_0_5V = 17'h07d00;
   localparam logic [16:0] K_0_10V = 17'h03e84;
   // Reciprocal of 1000 in 2^-20 units
   localparam logic [11:0] INV_1000 = 12'h419;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 10;
   localparam int SAMPLE_NS = 1000000;
   localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b01,
      MODE_DANCER = 2'b10
   } dps_mode_t;
   typedef struct packed {
      logic [7:0] action;
      logic [15:0] setPt;
      logic [15:0] upLim;
      logic [15:0] loLim;
      logic [1:0] fbRange;
      logic [7:0] outSelA;
      logic [7:0] outSelB;
      logic [7:0] inSel;
      logic [7:0] kp;
      logic [7:0] ki;
      logic [7:0] kd;
      logic [15:0] biasF;
      logic [15:0] gainF;
      logic [15:0] therm;
      logic [1:0] mainSrc;
      logic [15:0] acc2;
      logic [15:0] dec2;
   } dps_cfg_t;
   typedef struct packed {
      logic [15:0] term2Freq;
      logic [15:0] term4Freq;
      logic [15:0] digitalFreq;
      logic [15:0] outFreq;
      logic running;
      logic fwdShown;
   } dps_drive_t;
endpackage

// file: test/dps_partner.sv
// Far-side model: dancer roller position sensor and external speed source
`timescale 1ns/1ps
`default_nettype none
module dps_partner
   import dps_pkg::*;
(
   // Sensor position, per mille of travel, and selected electrical range
   input wire logic [10:0] posPm,
   input wire logic [1:0] fbRange,
   // Speed sources and drive state set by the bench
   input wire dps_drive_t speedSrc,
   // Signals seen by the block
   output logic [11:0] feedbackRaw,
   output dps_drive_t drive
);
   // ----------------------------------------
   // Sensor: 0..1000 per mille onto each range's ADC span
   // ----------------------------------------
   always_comb begin
      case (fbRange)
         RNG_4_20MA: feedbackRaw = 12'(32'(ADC_4MA) + 32'(posPm) * 3276 / 1000);
         RNG_0_5V: feedbackRaw = 12'(32'(posPm) * 2048 / 1000);
         default: feedbackRaw = 12'(32'(posPm) * 4095 / 1000);
      endcase
   end
   // Output suspension is held off on this side, as the configurer must keep it
   assign drive = speedSrc;
endmodule // dps_partner
`default_nettype wire

// file: test/dps_dancer_trim_tb.sv
// Self-checking bench of the dancer speed trim block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errTotal++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module dps_dancer_trim_tb;
   import dps_pkg::*;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, loopSel, outA, outB;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] speedCmd;
   logic [11:0] fbRaw;
   logic [10:0] posPm;
   logic [1:0] rng;
   dps_drive_t src, drv;
   int errTotal = 0;
   int samplesChecked = 0;
   dps_partner u_part (.posPm(posPm), .fbRange(rng), .speedSrc(src), .feedbackRaw(fbRaw),
      .drive(drv));
   dps_dancer_trim #(.SampleCyc(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drive(drv), .loopSelectInput(loopSel),
      .feedbackRaw(fbRaw), .speedCmd(speedCmd), .outTermA(outA), .outTermB(outB));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------
   // Bus and helper tasks
   // ----------------------------------------
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic clk(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // Wait on pready is bounded; a stuck slave ends the run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         errTotal++;
         giveVerdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK("read data", x, r)
      `CHK("read error", xe, e)
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic tReset();
      rdChk(OFS_ACTION, 32'h0, 1'b0);
      rdChk(OFS_SETPT, {16'h0, NO_FUNC}, 1'b0);
      rdChk(OFS_GAINF, {16'h0, GAINF_RST}, 1'b0);
      rdChk(OFS_MAINSRC, 32'h2, 1'b0);
      rdChk(8'h40, 32'h0, 1'b1);
      $display("test reset done");
   endtask
   task automatic tNormal();
      src.digitalFreq <= 16'h0bb8;
      src.term2Freq <= 16'h07d0;
      src.term4Freq <= 16'h0fa0;
      clk(3);
      `CHK("speed digital", 16'h0bb8, speedCmd)
      wr(OFS_MAINSRC, {30'h0, SRC_TERM4});
      clk(3);
      `CHK("speed term4", 16'h0fa0, speedCmd)
      wr(OFS_MAINSRC, {30'h0, SRC_TERM2});
      wr(OFS_THERM, 32'h64);
      clk(3);
      `CHK("speed therm", 16'h0, speedCmd)
      wr(OFS_THERM, {16'h0, NO_FUNC});
      clk(3);
      `CHK("speed term2", 16'h07d0, speedCmd)
      wr(OFS_MAINSRC, {30'h0, SRC_DIGITAL});
      $display("test normal done");
   endtask
   task automatic tDir();
      wr(OFS_OUTSEL, {16'h0, FN_DIR + FN_INVERT, FN_DIR});
      src.running <= 1'b1;
      src.fwdShown <= 1'b1;
      clk(3);
      `CHK("dir fwd", 2'b10, {outA, outB})
      src.fwdShown <= 1'b0;
      clk(3);
      `CHK("dir rev", 2'b01, {outA, outB})
      src.running <= 1'b0;
      src.fwdShown <= 1'b1;
      clk(3);
      `CHK("dir stop", 2'b01, {outA, outB})
      $display("test direction done");
   endtask
   task automatic tLoop();
      logic [7:0] code;
      wr(OFS_OUTSEL, {16'h0, FN_LOOP + FN_INVERT, FN_LOOP});
      for (code = 8'h27; code <= 8'h2c; code++) begin
         wr(OFS_ACTION, {24'h0, code});
         clk(3);
         `CHK("loop act", {2{code >= 8'h28 && code <= 8'h2b}} ^ 2'b01, {outA, outB})
      end
      wr(OFS_INSEL, {24'h0, IN_LOOP_SEL});
      wr(OFS_ACTION, {24'h0, ACT_FWD_FIX});
      clk(3);
      `CHK("loop gated", 2'b01, {outA, outB})
      loopSel <= 1'b1;
      clk(3);
      `CHK("loop stopped", 2'b10, {outA, outB})
      rdChk(OFS_ACTION, {24'h0, ACT_FWD_FIX}, 1'b0);
      loopSel <= 1'b0;
      wr(OFS_INSEL, 32'h0);
      $display("test loop select done");
   endtask
   task automatic tLimits();
      wr(OFS_OUTSEL, {16'h0, FN_LOWER, FN_UPPER});
      wr(OFS_UPLIM, 32'h1f4);
      wr(OFS_LOLIM, 32'hc8);
      for (int i = 0; i < 3; i++) begin
         rng <= 2'(i);
         wr(OFS_FBRANGE, i);
         posPm <= 11'd900;
         clk(40);
         `CHK("upper flag", 2'b10, {outA, outB})
         posPm <= 11'd100;
         clk(40);
         `CHK("lower flag", 2'b01, {outA, outB})
         posPm <= 11'd350;
         clk(40);
         `CHK("no flag", 2'b00, {outA, outB})
      end
      wr(OFS_UPLIM, {16'h0, NO_FUNC});
      posPm <= 11'd900;
      clk(40);
      `CHK("upper off", 2'b00, {outA, outB})
      $display("test limits done");
   endtask
   task automatic tCapture();
      wr(OFS_INSEL, {24'h0, IN_LOOP_SEL});
      src.running <= 1'b1;
      src.outFreq <= 16'h1194;
      clk(3);
      `CHK("before select", 16'h0bb8, speedCmd)
      loopSel <= 1'b1;
      clk(3);
      `CHK("captured", 16'h1194, speedCmd)
      loopSel <= 1'b0;
      clk(3);
      `CHK("released", 16'h0bb8, speedCmd)
      $display("test capture done");
   endtask
   // Feedback at full travel, set point left at 9999 (50 %), kp 8: correction 25 %
   task automatic tTrim();
      wr(OFS_GAINS, 32'h8);
      src.running <= 1'b0;
      posPm <= 11'd1000;
      clk(20);
      loopSel <= 1'b1;
      clk(30);
      `CHK("trim fixed", 16'h1194, speedCmd)
      wr(OFS_ACTION, {24'h0, ACT_FWD_RAT});
      clk(20);
      `CHK("trim ratio", 16'h0ea6, speedCmd)
      wr(OFS_MAINSRC, {30'h0, SRC_TERM4});
      rdChk(OFS_STATUS, 32'h03e80009, 1'b0);
      wr(OFS_MAINSRC, {30'h0, SRC_DIGITAL});
      loopSel <= 1'b0;
      clk(3);
      `CHK("trim off", 16'h0bb8, speedCmd)
      $display("test trim done");
   endtask
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, loopSel} = 4'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      posPm = 11'd500;
      rng = RNG_4_20MA;
      src = '0;
      clk(3);
      rst_n <= 1'b1;
      clk(1);
      tReset();
      tNormal();
      tDir();
      tLoop();
      tLimits();
      tCapture();
      tTrim();
      giveVerdict();
   end
endmodule // dps_dancer_trim_tb
`default_nettype wire
